// ---- logic/pmef_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module pmef_top #(
	parameter bit FULL_VARIANT = 1'b1 // Interrupt-controller variant present.
) (
	input wire logic CLK_SYS_I, // 50 MHz system clock.
	input wire logic RST_N_I, // Synchronous reset, active low.
	input wire logic PSEL_I, // APB select.
	input wire logic PENABLE_I, // APB access phase.
	input wire logic PWRITE_I, // APB direction, high for write.
	input wire logic [9:0] PADDR_I, // APB byte address.
	input wire logic [31:0] PWDATA_I, // APB write data.
	output logic [31:0] PRDATA_O, // APB read data.
	output logic PREADY_O, // APB ready.
	output logic PSLVERR_O, // APB error on unmapped address.
	input wire logic [15:0] IRQ_I, // Hardware interrupt lines, active high.
	input wire logic EXT_MGMT_REQUEST_N_I, // External management request, active low.
	input wire logic NMI_I, // Non-maskable interrupt, active high.
	input wire logic CPU_INTR_I, // CPU interrupt request, active high.
	input wire logic CPU_INIT_I, // CPU init, active high.
	input wire logic [3:0] ACTIVITY_I, // DMA, drive, parallel, serial activity.
	input wire logic STOP_GRANT_I, // Stop-grant special cycle seen.
	input wire logic MINUTE_TICK_I, // One-minute tick, asynchronous.
	output logic MGMT_INT_OUT_N_O, // Management interrupt, active low.
	output logic CPU_CLOCK_STOP_N_O, // CPU clock stop, active low.
	output logic MGMT_CYCLE_O // Pulse when the timer raises an event.
);

	// ------------------------------------------------------------------
	// Input synchronisation.
	// ------------------------------------------------------------------
	localparam int NIN = 16 + 1 + 1 + 1 + 1 + 4 + 1 + 1; // Synchronised inputs.

	pmef_sync_if #(.W(NIN)) sync_bus ();

	// All asynchronous input pins cross into the clock domain before any logic reads them.
	// Synchronise then detect edge.
	pmef_edge_sync #(.W(NIN)) u_sync (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.async_i({MINUTE_TICK_I, STOP_GRANT_I, ACTIVITY_I, CPU_INIT_I, CPU_INTR_I,
			NMI_I, ~EXT_MGMT_REQUEST_N_I, IRQ_I}),
		.out(sync_bus)
	);

	logic [15:0] irq_rise; // Line assertion pulses.
	logic ext_rise; // External request pulse.
	logic nmi_rise; // NMI pulse.
	logic intr_rise; // CPU interrupt pulse.
	logic init_rise; // Init pulse.
	logic init_level; // Init level after synchronisation.
	logic [3:0] act_rise; // Peripheral activity pulses.
	logic grant_rise; // Stop-grant pulse.
	logic tick_rise; // Minute tick pulse.

	assign irq_rise = sync_bus.rise[15:0];
	assign ext_rise = sync_bus.rise[16];
	assign nmi_rise = sync_bus.rise[17];
	assign intr_rise = sync_bus.rise[18];
	assign init_rise = sync_bus.rise[19];
	assign init_level = sync_bus.level[19];
	assign act_rise = sync_bus.rise[23:20];
	assign grant_rise = sync_bus.rise[24];
	assign tick_rise = sync_bus.rise[25];

	// ------------------------------------------------------------------
	// APB slave.
	// ------------------------------------------------------------------
	logic [7:0] ctl; // Control byte.
	logic [15:0] src_en; // Interrupt-source enable.
	logic [31:0] evt_en; // Event enable.
	logic [7:0] tmr_start; // Timer start count.
	logic [7:0] status; // Event status bits.
	logic stop_req; // Clock-stop request from software.
	logic wr_en; // Write taken this cycle.
	logic rd_en; // Read taken this cycle.
	logic hit; // Address maps to a register.
	logic [31:0] evt_mask; // Writable event bits for this variant.
	logic [7:0] tmr_count; // Current timer count.
	logic tmr_expire; // Timer expiry pulse.

	// Decodes a mapped address; used by the error logic only.
	function automatic logic addr_mapped(input logic [9:0] a);
		addr_mapped = (a == pmef_pkg::ADDR_CONTROL) || (a == pmef_pkg::ADDR_SRC_EN) ||
			(a == pmef_pkg::ADDR_EVT_EN) || (a == pmef_pkg::ADDR_TMR_START) ||
			(a == pmef_pkg::ADDR_STATUS) || (a == pmef_pkg::ADDR_PM_PORT) ||
			(a == pmef_pkg::ADDR_CLK_STOP);
	endfunction

	assign evt_mask = FULL_VARIANT ? pmef_pkg::EVT_MASK_FULL : pmef_pkg::EVT_MASK_BASIC;
	assign hit = addr_mapped(PADDR_I);
	// Zero-wait slave: every access completes in its first access cycle.
	assign PREADY_O = 1'b1;
	assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
	assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;

	// Control register; reserved bits stay zero.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			ctl <= pmef_pkg::CTL_RESET;
		end else if (wr_en && PADDR_I == pmef_pkg::ADDR_CONTROL) begin
			ctl <= PWDATA_I[7:0] & pmef_pkg::CTL_MASK;
		end
	end

	// Enable registers.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			src_en <= pmef_pkg::SRC_EN_RESET;
			evt_en <= pmef_pkg::EVT_EN_RESET;
		end else if (wr_en) begin
			if (PADDR_I == pmef_pkg::ADDR_SRC_EN) begin
				src_en <= PWDATA_I[15:0] & pmef_pkg::SRC_EN_MASK;
			end
			if (PADDR_I == pmef_pkg::ADDR_EVT_EN) begin
				evt_en <= PWDATA_I & evt_mask;
			end
		end
	end

	// Start count; a write while the timer runs is accepted, but the
	// running count only picks it up at the next reload.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			tmr_start <= pmef_pkg::TMR_START_RESET;
		end else if (wr_en && PADDR_I == pmef_pkg::ADDR_TMR_START) begin
			tmr_start <= PWDATA_I[7:0];
		end
	end

	// Read data registered in the setup cycle so it is stable in access.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			PRDATA_O <= pmef_pkg::READ_ZERO;
		end else if (rd_en) begin
			unique case (PADDR_I)
				pmef_pkg::ADDR_CONTROL: begin
					PRDATA_O <= {24'h000000, ctl};
				end
				pmef_pkg::ADDR_SRC_EN: begin
					PRDATA_O <= {16'h0000, src_en};
				end
				pmef_pkg::ADDR_EVT_EN: begin
					PRDATA_O <= evt_en;
				end
				pmef_pkg::ADDR_TMR_START: begin
					PRDATA_O <= {24'h000000, tmr_start};
				end
				pmef_pkg::ADDR_STATUS: begin
					PRDATA_O <= {24'h000000, status};
				end
				pmef_pkg::ADDR_PM_PORT: begin
					PRDATA_O <= {24'h000000, tmr_count};
				end
				pmef_pkg::ADDR_CLK_STOP: begin
					PRDATA_O <= {31'h00000000, stop_req};
				end
				default: begin
					PRDATA_O <= pmef_pkg::READ_ZERO;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Event sources.
	// ------------------------------------------------------------------
	logic pm_port_wr; // Write to the power control port.
	logic [7:0] src_raw; // Raw per-source events in status order.
	logic [7:0] src_hit; // Enabled source events.
	logic sys_event; // Any enabled system event.
	logic brk_event; // Any enabled break event.
	logic [15:0] irq_evt; // Line events gated by event enables.

	assign pm_port_wr = wr_en && PADDR_I == pmef_pkg::ADDR_PM_PORT;

	// Lines 12, 8, 4, 3, 1 feed bits 4:0.
	assign src_raw = {pm_port_wr, ext_rise, tmr_expire, irq_rise[12], irq_rise[8],
		irq_rise[4], irq_rise[3], irq_rise[1]};
	// Enabled events count in any power state.
	assign src_hit = src_raw & src_en[7:0];

	// Line 2 is reserved, masked out above.
	assign irq_evt = irq_rise & evt_en[15:0];

	// Management and NMI are system and break events.
	assign sys_event = (|irq_evt) || (evt_en[pmef_pkg::EVT_MGMT_BIT] && (|src_hit)) ||
		(evt_en[pmef_pkg::EVT_NMI_BIT] && nmi_rise) ||
		(|(act_rise & evt_en[pmef_pkg::EVT_ACT_LO +: pmef_pkg::NUM_ACT]));
	// CPU interrupt is a break event only.
	assign brk_event = (|irq_evt) || (evt_en[pmef_pkg::EVT_MGMT_BIT] && (|src_hit)) ||
		(evt_en[pmef_pkg::EVT_NMI_BIT] && nmi_rise) ||
		(evt_en[pmef_pkg::EVT_CPU_INT_BIT] && intr_rise);

	// ------------------------------------------------------------------
	// Status register.
	// ------------------------------------------------------------------
	// Software writes 0 to clear a bit; a new event in the same cycle wins.
	// Each bit is set by an edge, so a held source is reported once.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			status <= 8'h00;
		end else if (wr_en && PADDR_I == pmef_pkg::ADDR_STATUS) begin
			status <= (status & PWDATA_I[7:0]) | src_hit;
		end else begin
			status <= status | src_hit;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt output.
	// ------------------------------------------------------------------
	// Registered pin: asserts the cycle after status or gate changes.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			MGMT_INT_OUT_N_O <= 1'b1;
		end else begin
			// Gate high drives pending to pin.
			// Pending status asserts once gated on.
			MGMT_INT_OUT_N_O <= !(ctl[pmef_pkg::CTL_GATE_BIT] && (|status));
		end
	end

	// ------------------------------------------------------------------
	// Inactivity timer.
	// ------------------------------------------------------------------
	// Decrement per minute tick.
	pmef_minute_timer u_timer (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.tick_i(tick_rise),
		.freeze_i(ctl[pmef_pkg::CTL_FREEZE_BIT]),
		.reload_i(sys_event),
		.start_i(tmr_start),
		.expire_o(tmr_expire),
		.count_o(tmr_count)
	);

	// Relies on software freezing before start writes.
	assign MGMT_CYCLE_O = tmr_expire;

	// ------------------------------------------------------------------
	// Clock-stop control.
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PMEF_RUN_S = 2'b00, // CPU clock running.
		PMEF_WAIT_S = 2'b01, // Stop asserted, waiting for stop-grant.
		PMEF_STOP_S = 2'b10 // Stop-grant received, CPU halted.
	} pmef_stop_t;

	pmef_stop_t stop_state; // Clock-stop state.
	logic brk_latched; // Break seen before stop-grant.

	// Software requests stop by writing 1; the state machine consumes it.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			stop_req <= 1'b0;
		end else if (wr_en && PADDR_I == pmef_pkg::ADDR_CLK_STOP) begin
			stop_req <= PWDATA_I[0];
		end else if (stop_state != PMEF_RUN_S) begin
			stop_req <= 1'b0;
		end
	end

	// Init is ignored until stop-grant, so an early pulse does nothing.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			stop_state <= PMEF_RUN_S;
			brk_latched <= 1'b0;
		end else begin
			unique case (stop_state)
				PMEF_RUN_S: begin
					brk_latched <= 1'b0;
					if (stop_req) begin
						stop_state <= PMEF_WAIT_S;
					end
				end
				PMEF_WAIT_S: begin
					if (brk_event) begin
						brk_latched <= 1'b1;
					end
					if (grant_rise) begin
						stop_state <= (brk_latched || brk_event) ? PMEF_RUN_S : PMEF_STOP_S;
					end
				end
				PMEF_STOP_S: begin
					if (brk_event || init_rise || init_level) begin
						stop_state <= PMEF_RUN_S;
					end
				end
				default: begin
					stop_state <= PMEF_RUN_S;
				end
			endcase
		end
	end

	// Registered so the pin never glitches between states.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			CPU_CLOCK_STOP_N_O <= 1'b1;
		end else begin
			CPU_CLOCK_STOP_N_O <= (stop_state == PMEF_RUN_S) && !stop_req;
		end
	end

endmodule

`default_nettype wire

// ---- logic/pmef_pkg.sv ----
package pmef_pkg;

	// ------------------------------------------------------------------
	// Register indices; each register is one word at four times its index.
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_CONTROL = 8'hA0; // Control byte: gate and freeze.
	localparam logic [7:0] IDX_SRC_EN = 8'hA2; // Interrupt-source enable.
	localparam logic [7:0] IDX_EVT_EN = 8'hA4; // System and break event enable.
	localparam logic [7:0] IDX_TMR_START = 8'hA8; // Inactivity timer start count.
	localparam logic [7:0] IDX_STATUS = 8'hAC; // Event status, write 0 to clear.
	localparam logic [7:0] IDX_PM_PORT = 8'hB0; // Power control port.
	localparam logic [7:0] IDX_CLK_STOP = 8'hB4; // Clock-stop request.
	localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00}; // Byte addresses.
	localparam logic [9:0] ADDR_SRC_EN = {IDX_SRC_EN, 2'b00};
	localparam logic [9:0] ADDR_EVT_EN = {IDX_EVT_EN, 2'b00};
	localparam logic [9:0] ADDR_TMR_START = {IDX_TMR_START, 2'b00};
	localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [9:0] ADDR_PM_PORT = {IDX_PM_PORT, 2'b00};
	localparam logic [9:0] ADDR_CLK_STOP = {IDX_CLK_STOP, 2'b00};

	// ------------------------------------------------------------------
	// Field positions and reset values.
	// ------------------------------------------------------------------
	localparam int CTL_GATE_BIT = 0; // Output gate of the interrupt pin.
	localparam int CTL_FREEZE_BIT = 3; // Timer freeze.
	localparam logic [7:0] CTL_RESET = 8'h08; // Timer frozen after reset.
	localparam logic [7:0] CTL_MASK = 8'h09; // Implemented control bits.
	localparam logic [15:0] SRC_EN_RESET = 16'h0000; // All sources disabled.
	localparam logic [15:0] SRC_EN_MASK = 16'h00FF; // Bits 15:8 reserved.
	localparam logic [31:0] EVT_EN_RESET = 32'h00000000; // All events disabled.
	localparam logic [31:0] EVT_MASK_BASIC = 32'hA000FFFB; // Common variant bits.
	localparam logic [31:0] EVT_MASK_FULL = 32'hEF00FFFB; // Interrupt-controller variant.
	localparam logic [7:0] TMR_START_RESET = 8'h0F; // Fifteen minutes.
	localparam logic [7:0] TMR_ZERO = 8'h00; // Expiry count.
	localparam logic [7:0] TMR_STEP = 8'h01; // One minute decrement.
	localparam int SRC_PM_PORT = 7; // Status bit for power port write.
	localparam int SRC_EXT = 6; // Status bit for external request.
	localparam int SRC_TIMER = 5; // Status bit for timer expiry.
	localparam int EVT_MGMT_BIT = 31; // Management interrupt as event.
	localparam int EVT_CPU_INT_BIT = 30; // CPU interrupt as break event.
	localparam int EVT_NMI_BIT = 29; // Non-maskable interrupt as event.
	localparam int EVT_ACT_LO = 24; // Lowest peripheral activity bit.
	localparam int NUM_IRQ = 16; // Interrupt lines watched.
	localparam int NUM_ACT = 4; // Serial, parallel, drive, DMA.
	localparam logic [31:0] READ_ZERO = 32'h00000000; // Unmapped read data.

endpackage

// ---- logic/pmef_sync_if.sv ----
`timescale 1ns/10ps
`default_nettype none

// Carries synchronised edge pulses from the input stage to the core.
interface pmef_sync_if #(parameter int W = 1);
	logic [W-1:0] level; // Synchronised level.
	logic [W-1:0] rise; // One-cycle pulse on assertion.
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

`default_nettype wire

// ---- logic/pmef_edge_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser with a rising-edge detector behind the second flop.
module pmef_edge_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // System clock.
	input wire logic rst_n_i, // Synchronous reset, active low.
	input wire logic [W-1:0] async_i, // Active-high asynchronous inputs.
	pmef_sync_if.src out // Synchronised levels and rising pulses.
);

	logic [W-1:0] meta; // First stage, read only by the second.
	logic [W-1:0] stable; // Second stage.
	logic [W-1:0] prev; // Delayed copy for edge detection.

	// ------------------------------------------------------------------
	// Synchroniser chain.
	// ------------------------------------------------------------------
	// The edge detector looks only at the second and third flops.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			stable <= '0;
			prev <= '0;
		end else begin
			meta <= async_i;
			stable <= meta;
			prev <= stable;
		end
	end

	assign out.level = stable;
	assign out.rise = stable & ~prev;

endmodule

`default_nettype wire

// ---- logic/pmef_minute_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// Inactivity count-down timer, stepped by a synchronised minute tick.
module pmef_minute_timer (
	input wire logic clk_i, // System clock.
	input wire logic rst_n_i, // Synchronous reset, active low.
	input wire logic tick_i, // One-cycle pulse per minute.
	input wire logic freeze_i, // Stop counting while high.
	input wire logic reload_i, // System event: reload start count.
	input wire logic [7:0] start_i, // Programmed start count.
	output logic expire_o, // One-cycle pulse when zero is reached.
	output logic [7:0] count_o // Current count.
);

	logic [7:0] count; // Count-down register.

	// ------------------------------------------------------------------
	// Counter.
	// ------------------------------------------------------------------
	// Reaching zero reloads at once, so a start count of zero would fire
	// every clock cycle; software is expected never to program it.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			count <= pmef_pkg::TMR_START_RESET;
			expire_o <= 1'b0;
		end else begin
			expire_o <= 1'b0;
			if (reload_i) begin
				count <= start_i;
			end else if (count == pmef_pkg::TMR_ZERO) begin
				expire_o <= 1'b1;
				count <= start_i;
			end else if (tick_i && !freeze_i) begin
				count <= count - pmef_pkg::TMR_STEP;
			end
		end
	end

	assign count_o = count;

endmodule

`default_nettype wire

// ---- tb/pmef_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Checker on the top module pins.
// ------------------------------------------------------------------
module pmef_sva (
	input wire logic CLK_SYS_I, // Clock.
	input wire logic RST_N_I, // Reset, active low.
	input wire logic PSEL_I, // Select.
	input wire logic PENABLE_I, // Access phase.
	input wire logic PWRITE_I, // Direction.
	input wire logic [9:0] PADDR_I, // Address.
	input wire logic [31:0] PWDATA_I, // Write data.
	input wire logic PREADY_O, // Ready.
	input wire logic PSLVERR_O, // Error.
	input wire logic [15:0] IRQ_I, // Interrupt lines.
	input wire logic STOP_GRANT_I, // Stop-grant.
	input wire logic MGMT_INT_OUT_N_O, // Interrupt pin.
	input wire logic CPU_CLOCK_STOP_N_O, // Clock-stop pin.
	input wire logic MGMT_CYCLE_O // Expiry pulse.
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);
	logic wr; // A write completes at this edge.
	logic map_hit; // Address is decoded.
	logic gate; // Shadow of the output gate.
	logic [7:0] src_en; // Shadow of the source enables.
	logic got_grant; // Stop-grant seen while the clock is stopped.
	assign wr = PSEL_I && PENABLE_I && PWRITE_I;
	assign map_hit = PADDR_I inside {pmef_pkg::ADDR_CONTROL, pmef_pkg::ADDR_SRC_EN,
		pmef_pkg::ADDR_EVT_EN, pmef_pkg::ADDR_TMR_START, pmef_pkg::ADDR_STATUS,
		pmef_pkg::ADDR_PM_PORT, pmef_pkg::ADDR_CLK_STOP};
	// The gate is shadowed from writes so the pin is judged by its cause.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			gate <= 1'b0;
		end else if (wr && PADDR_I == pmef_pkg::ADDR_CONTROL) begin
			gate <= PWDATA_I[0];
		end
	end
	// Source enables are shadowed the same way.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			src_en <= 8'h00;
		end else if (wr && PADDR_I == pmef_pkg::ADDR_SRC_EN) begin
			src_en <= PWDATA_I[7:0];
		end
	end
	// Cleared while the clock runs, so a wake-up without a grant shows up.
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I || CPU_CLOCK_STOP_N_O) begin
			got_grant <= 1'b0;
		end else if (STOP_GRANT_I) begin
			got_grant <= 1'b1;
		end
	end
	sequence s_pin_low;
		##[1:10] !MGMT_INT_OUT_N_O;
	endsequence
	sequence s_stop_low;
		##[1:4] !CPU_CLOCK_STOP_N_O;
	endsequence
	a_gate_masks_pin: assert property (!$past(gate) |-> MGMT_INT_OUT_N_O)
		else $error("interrupt pin low with gate off");
	a_line_raises_pin: assert property (gate && src_en[0] && $rose(IRQ_I[1]) |-> s_pin_low)
		else $error("enabled line did not assert interrupt pin");
	a_port_raises_pin: assert property (wr && PADDR_I == pmef_pkg::ADDR_PM_PORT && gate
		&& src_en[7] |-> s_pin_low)
		else $error("port write did not assert interrupt pin");
	a_expiry_raises_pin: assert property (MGMT_CYCLE_O && gate && src_en[5] |-> s_pin_low)
		else $error("timer expiry did not assert interrupt pin");
	a_expiry_one_pulse: assert property (MGMT_CYCLE_O |=> !MGMT_CYCLE_O)
		else $error("expiry pulse longer than one cycle");
	a_wake_after_grant: assert property ($rose(CPU_CLOCK_STOP_N_O) |-> got_grant)
		else $error("clock stop released before stop-grant");
	a_stop_request: assert property (wr && PADDR_I == pmef_pkg::ADDR_CLK_STOP && PWDATA_I[0]
		&& CPU_CLOCK_STOP_N_O |-> s_stop_low)
		else $error("clock stop request not honoured");
	a_ready_error: assert property (PSEL_I && PENABLE_I |-> PREADY_O && PSLVERR_O == !map_hit)
		else $error("bad ready or error response");
endmodule

bind pmef_top pmef_sva u_sva (.CLK_SYS_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
	.PWDATA_I, .PREADY_O, .PSLVERR_O, .IRQ_I, .STOP_GRANT_I, .MGMT_INT_OUT_N_O,
	.CPU_CLOCK_STOP_N_O, .MGMT_CYCLE_O);

`default_nettype wire

// ---- tb/pmef_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// CPU side: answers a clock stop with one stop-grant cycle after a delay.
module pmef_cpu_model #(
	parameter int GRANT_DLY = 3 // Cycles from stop to grant.
) (
	input wire logic clk_i, // Clock.
	input wire logic rst_n_i, // Reset, active low.
	input wire logic clock_stop_n_i, // Clock-stop pin from the block.
	input wire logic hold_i, // Holds the grant back while high.
	output logic stop_grant_o // Stop-grant cycle, high for two cycles.
);
	int cnt; // Cycles since the stop was seen.
	logic done; // Grant already given for this stop.
	// One grant per stop; a held grant lets breaks pile up before it.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || clock_stop_n_i) begin
			cnt <= 0;
			done <= 1'b0;
			stop_grant_o <= 1'b0;
		end else if (!done && !hold_i) begin
			cnt <= cnt + 1;
			stop_grant_o <= (cnt >= GRANT_DLY);
			done <= (cnt == GRANT_DLY + 1);
		end else if (done) begin
			stop_grant_o <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// ---- tb/power_mgmt_event_fastoff_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module power_mgmt_event_fastoff_tb_top;
	typedef struct packed {logic w; logic [9:0] a; logic [31:0] d; logic [31:0] e;} pmef_row_t;
	logic clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, last_err, ext_n = 1'b1, init = 1'b0, tick = 1'b0, hold = 1'b0;
	logic [15:0] irq = 16'h0000;
	logic [3:0] act = 4'h0;
	logic nmi = 1'b0, intr = 1'b0;
	logic grant, smi_n, stop_n, mcycle;
	int error_cnt = 0, checked = 0, cyc = 0, cyc_pulses = 0;
	int lines [6] = '{1, 3, 4, 8, 12, 16}; // IRQ lines of source bits 0..4, then external.
	logic [31:0] stat [6] = '{32'h01, 32'h02, 32'h04, 32'h08, 32'h10, 32'h40};
	// Reset values first, then write rows read back through the reserved-bit masks.
	pmef_row_t rows [9] = '{'{1'b0, pmef_pkg::ADDR_CONTROL, 32'h0, 32'h08},
		'{1'b0, pmef_pkg::ADDR_SRC_EN, 32'h0, 32'h0}, '{1'b0, pmef_pkg::ADDR_EVT_EN, 32'h0, 32'h0},
		'{1'b0, pmef_pkg::ADDR_TMR_START, 32'h0, 32'h0F}, '{1'b0, pmef_pkg::ADDR_STATUS, 32'h0, 32'h0},
		'{1'b1, pmef_pkg::ADDR_SRC_EN, 32'hFFFFFFFF, 32'hFF},
		'{1'b1, pmef_pkg::ADDR_EVT_EN, 32'hFFFFFFFF, 32'hEF00FFFB},
		'{1'b1, pmef_pkg::ADDR_TMR_START, 32'h5A, 32'h5A}, '{1'b1, 10'h300, 32'hFFFFFFFF, 32'h0}};

	pmef_top #(.FULL_VARIANT(1'b1)) u_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_I(irq),
		.EXT_MGMT_REQUEST_N_I(ext_n), .NMI_I(nmi), .CPU_INTR_I(intr), .CPU_INIT_I(init),
		.ACTIVITY_I(act), .STOP_GRANT_I(grant), .MINUTE_TICK_I(tick),
		.MGMT_INT_OUT_N_O(smi_n), .CPU_CLOCK_STOP_N_O(stop_n), .MGMT_CYCLE_O(mcycle));
	pmef_cpu_model u_cpu (.clk_i(clk), .rst_n_i(rst_n), .clock_stop_n_i(stop_n),
		.hold_i(hold), .stop_grant_o(grant));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard: the sequence needs a few hundred cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		cyc_pulses <= cyc_pulses + (mcycle === 1'b1);
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// The request is held until ready is seen high at an edge.
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rdc(input logic [9:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	// Index 0..15 is a line, 16 the external request, 17 init, 18 the minute tick,
	// 19 the NMI, 20 the CPU interrupt and 21 all four activity inputs.
	task automatic pulse(input int i);
		if (i < 16) irq[i] <= 1'b1;
		else if (i == 16) ext_n <= 1'b0;
		else if (i == 17) init <= 1'b1;
		else if (i == 18) tick <= 1'b1;
		else if (i == 19) nmi <= 1'b1;
		else if (i == 20) intr <= 1'b1;
		else act <= 4'hF;
		repeat (4) @(posedge clk);
		irq <= 16'h0000;
		ext_n <= 1'b1;
		init <= 1'b0;
		tick <= 1'b0;
		nmi <= 1'b0;
		intr <= 1'b0;
		act <= 4'h0;
		repeat (8) @(posedge clk);
	endtask
	task automatic wait_pin(input bit s, input logic v);
		for (int k = 0; k < 30; k++) begin
			if ((s ? stop_n : smi_n) === v) break;
			@(posedge clk);
		end
		chk({31'h0, (s ? stop_n : smi_n)}, {31'h0, v});
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e);
			chk({31'h0, last_err}, {31'h0, rows[i].a == 10'h300});
		end
		$display("test register table done");
		wr(pmef_pkg::ADDR_SRC_EN, 32'h01);
		wr(pmef_pkg::ADDR_EVT_EN, 32'h0);
		pulse(1);
		chk({31'h0, smi_n}, 32'h1);
		rdc(pmef_pkg::ADDR_STATUS, 32'h01);
		wr(pmef_pkg::ADDR_CONTROL, 32'h09);
		wait_pin(1'b0, 1'b0);
		wr(pmef_pkg::ADDR_STATUS, 32'h0);
		wait_pin(1'b0, 1'b1);
		irq[1] <= 1'b1;
		wait_pin(1'b0, 1'b0);
		wr(pmef_pkg::ADDR_STATUS, 32'h0);
		repeat (8) @(posedge clk);
		rdc(pmef_pkg::ADDR_STATUS, 32'h0);
		chk({31'h0, smi_n}, 32'h1);
		irq[1] <= 1'b0;
		$display("test gate and edge done");
		wr(pmef_pkg::ADDR_SRC_EN, 32'hFF);
		foreach (lines[k]) begin
			pulse(lines[k]);
			rdc(pmef_pkg::ADDR_STATUS, stat[k]);
			wr(pmef_pkg::ADDR_STATUS, 32'h0);
		end
		wr(pmef_pkg::ADDR_PM_PORT, 32'h0);
		rdc(pmef_pkg::ADDR_STATUS, 32'h80);
		wr(pmef_pkg::ADDR_STATUS, 32'h0);
		$display("test sources done");
		// the timer stays frozen while its start count is written.
		wr(pmef_pkg::ADDR_TMR_START, 32'h03);
		wr(pmef_pkg::ADDR_SRC_EN, 32'h20);
		wr(pmef_pkg::ADDR_EVT_EN, 32'h02);
		wr(pmef_pkg::ADDR_CONTROL, 32'h01);
		pulse(1);
		rdc(pmef_pkg::ADDR_PM_PORT, 32'h03);
		pulse(18);
		rdc(pmef_pkg::ADDR_PM_PORT, 32'h02);
		wr(pmef_pkg::ADDR_CONTROL, 32'h09);
		pulse(18);
		rdc(pmef_pkg::ADDR_PM_PORT, 32'h02);
		wr(pmef_pkg::ADDR_CONTROL, 32'h01);
		pulse(18);
		pulse(18);
		rdc(pmef_pkg::ADDR_PM_PORT, 32'h03);
		rdc(pmef_pkg::ADDR_STATUS, 32'h20);
		chk(cyc_pulses, 32'h1);
		wr(pmef_pkg::ADDR_CONTROL, 32'h09);
		wr(pmef_pkg::ADDR_STATUS, 32'h0);
		$display("test timer done");
		wr(pmef_pkg::ADDR_EVT_EN, 32'h20000008);
		hold <= 1'b1;
		wr(pmef_pkg::ADDR_CLK_STOP, 32'h1);
		wait_pin(1'b1, 1'b0);
		pulse(17);
		hold <= 1'b0;
		repeat (12) @(posedge clk);
		chk({31'h0, stop_n}, 32'h0);
		pulse(3);
		wait_pin(1'b1, 1'b1);
		hold <= 1'b1;
		wr(pmef_pkg::ADDR_CLK_STOP, 32'h1);
		wait_pin(1'b1, 1'b0);
		pulse(19);
		chk({31'h0, stop_n}, 32'h0);
		hold <= 1'b0;
		wait_pin(1'b1, 1'b1);
		wr(pmef_pkg::ADDR_CLK_STOP, 32'h1);
		repeat (12) @(posedge clk);
		pulse(17);
		wait_pin(1'b1, 1'b1);
		wr(pmef_pkg::ADDR_EVT_EN, 32'h4F000000);
		wr(pmef_pkg::ADDR_CLK_STOP, 32'h1);
		repeat (12) @(posedge clk);
		pulse(21);
		chk({31'h0, stop_n}, 32'h0);
		pulse(20);
		wait_pin(1'b1, 1'b1);
		$display("test clock stop done");
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(pmef_pkg::ADDR_SRC_EN, 32'h0);
		rdc(pmef_pkg::ADDR_TMR_START, 32'h0F);
		chk({31'h0, smi_n}, 32'h1);
		$display("test second reset done");
		test_done();
	end
endmodule

`default_nettype wire
